// [scan_test_consts.svh]
// Constants for the scan chain and embedded memory test block.
`ifndef SCAN_TEST_CONSTS_SVH
`define SCAN_TEST_CONSTS_SVH
`define CHAINS 4
`define CHAIN_LEN 21
`define ST_W 84
`define ST_RST 84'h0
`define MEM_DEPTH 128
`define MEM_AW 7
`define MEM_DW 16
`define BYTE_MASK 16'h00ff
`define F_CFG 0
`define F_KIND 0
`define KIND_W 2
`define F_NARROW 2
`define F_WDATA 3
`define F_WADDR 19
`define F_RADDR 26
`define F_RDATA 33
`define F_SCR 49
`define F_RD 65
`define F_SPARE 81
`define SPARE_W 3
`define SPARE_PARK 3'h0
`define CFG_W 3
`define A_CFG 8'h00
`define A_WDATA 8'h04
`define A_WADDR 8'h08
`define A_RADDR 8'h0c
`define A_RDATA 8'h10
`define A_SCR 8'h14
`define A_STATUS 8'h18
`endif

// [scan_test_pkg.sv]
// Types for the scan chain and embedded memory test block.
package scan_test_pkg;
  typedef enum logic [1:0] {
    kind_ram = 2'b00,
    kind_rom = 2'b01,
    kind_pterm = 2'b10
  } kind_t;
endpackage

// [scan_mem_test.sv]
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Scan chains, embedded memory test mode and register port of the test block.
`include "scan_test_consts.svh"

module scan_mem_test (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_test_mode,
  input wire logic i_scan_en,
  input wire logic i_mem_test,
  input wire logic [3:0] i_scan_in,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  output logic [3:0] o_scan_out
);

  logic [`ST_W-1:0] st;
  logic [`ST_W-1:0] func_st;
  logic [`ST_W-1:0] next_st;
  logic [`MEM_DW-1:0] mem [`MEM_DEPTH];
  logic [`MEM_DW-1:0] next_mem [`MEM_DEPTH];
  logic shift;
  logic mtest;
  logic narrow;
  logic apb_wr;
  logic wr_en;
  logic [`MEM_AW-1:0] wr_a;
  logic [`MEM_DW-1:0] wr_d;
  logic [`MEM_DW-1:0] rd_word;
  logic [`MEM_DW-1:0] rd_mux;
  scan_test_pkg::kind_t kind;

  // Bytes-only user organisation masks the upper half of each word.
  function automatic logic [`MEM_DW-1:0] fit(
    input logic [`MEM_DW-1:0] d,
    input logic nar
  );
    fit = nar ? (d & `BYTE_MASK) : d;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `A_CFG) || (a == `A_WDATA) || (a == `A_WADDR) ||
      (a == `A_RADDR) || (a == `A_RDATA) || (a == `A_SCR) ||
      (a == `A_STATUS);
  endfunction

  // Only a RAM organisation takes writes; ROM and product-term arrays keep their contents.
  function automatic logic is_ram(input scan_test_pkg::kind_t k);
    is_ram = (k == scan_test_pkg::kind_ram);
  endfunction

  function automatic int chain_base(input int c);
    chain_base = c * `CHAIN_LEN;
  endfunction

  // The test pins are tied low in the end system, so no test path can act.
  assign shift = i_test_mode & i_scan_en;
  assign mtest = i_test_mode & i_mem_test & ~i_scan_en;
  assign apb_wr = i_psel & i_penable & i_pwrite & ~i_test_mode;
  assign kind = scan_test_pkg::kind_t'(st[`F_KIND +: `KIND_W]);
  assign narrow = st[`F_NARROW];
  assign rd_word = mem[st[`F_RADDR +: `MEM_AW]];

  always_comb begin
    unique case (i_paddr)
      `A_CFG: rd_mux = {13'h0, st[`F_CFG +: `CFG_W]};
      `A_WDATA: rd_mux = st[`F_WDATA +: `MEM_DW];
      `A_WADDR: rd_mux = {9'h0, st[`F_WADDR +: `MEM_AW]};
      `A_RADDR: rd_mux = {9'h0, st[`F_RADDR +: `MEM_AW]};
      `A_RDATA: rd_mux = st[`F_RDATA +: `MEM_DW];
      `A_SCR: rd_mux = st[`F_SCR +: `MEM_DW];
      `A_STATUS: rd_mux = {13'h0, i_scan_en, i_mem_test, i_test_mode};
      default: rd_mux = 16'h0;
    endcase
  end

  // Functional next values: what every register loads when not shifting.
  always_comb begin
    func_st = st;
    wr_en = 1'b0;
    wr_a = st[`F_WADDR +: `MEM_AW];
    wr_d = fit(st[`F_WDATA +: `MEM_DW], narrow);
    func_st[`F_SPARE +: `SPARE_W] = `SPARE_PARK;
    // Read data is latched at the setup edge so that it stands through the access phase.
    if (i_psel && !i_penable) begin
      func_st[`F_RD +: `MEM_DW] = rd_mux;
    end
    if (mtest) begin
      // Test organisation is always the full 128x16 array.
      wr_d = st[`F_WDATA +: `MEM_DW];
      wr_en = i_write_strobe && is_ram(kind);
      if (i_read_strobe) begin
        func_st[`F_RDATA +: `MEM_DW] = rd_word;
      end
    end else if (!i_test_mode) begin
      func_st[`F_RDATA +: `MEM_DW] = fit(rd_word, narrow);
      if (apb_wr) begin
        unique case (i_paddr)
          `A_CFG: func_st[`F_CFG +: `CFG_W] = i_pwdata[`CFG_W-1:0];
          `A_WDATA: begin
            func_st[`F_WDATA +: `MEM_DW] = i_pwdata[`MEM_DW-1:0];
            wr_d = fit(i_pwdata[`MEM_DW-1:0], narrow);
            wr_en = is_ram(kind);
          end
          `A_WADDR: func_st[`F_WADDR +: `MEM_AW] = i_pwdata[`MEM_AW-1:0];
          `A_RADDR: func_st[`F_RADDR +: `MEM_AW] = i_pwdata[`MEM_AW-1:0];
          `A_SCR: func_st[`F_SCR +: `MEM_DW] = i_pwdata[`MEM_DW-1:0];
          default: func_st[`F_SCR +: `MEM_DW] = st[`F_SCR +: `MEM_DW];
        endcase
      end
    end
  end

  // One select picks functional data or the serial neighbour for every bit.
  always_comb begin
    next_st = func_st;
    if (shift) begin
      for (int c = 0; c < `CHAINS; c++) begin
        next_st[chain_base(c) +: `CHAIN_LEN] =
          {st[chain_base(c) +: `CHAIN_LEN-1], i_scan_in[c]};
      end
    end
  end

  always_comb begin
    for (int c = 0; c < `CHAINS; c++) begin
      o_scan_out[c] = st[chain_base(c) + `CHAIN_LEN - 1];
    end
  end

  // Memory I/O registers live in st, so they shift with the chains.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= `ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // The array has no reset, so a word stays unknown until it is written.
  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_a] = wr_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    mem <= next_mem;
  end

  assign o_pready = 1'b1;
  assign o_prdata = {16'h0, st[`F_RD +: `MEM_DW]};
  assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  chk_chain_link: assert property (
    shift |=> st[1] == $past(st[0])
  ) else $error("Chain zero did not shift.");

  chk_parallel_in: assert property (
    shift |=> st[`CHAIN_LEN] == $past(i_scan_in[1]) && st[0] == $past(i_scan_in[0])
  ) else $error("Parallel chain inputs were not taken.");

  chk_scan_out: assert property (
    shift ##1 shift |=> o_scan_out[3] == $past(st[`ST_W-3], 2)
  ) else $error("Scan output does not follow the chain tail.");

  chk_user_mux: assert property (
    apb_wr && i_paddr == `A_SCR |=> st[`F_SCR +: `MEM_DW] == $past(i_pwdata[`MEM_DW-1:0])
  ) else $error("Functional data was not passed in user mode.");

  chk_wr_on_chain: assert property (
    shift |=> st[`F_WADDR] == $past(st[`F_WADDR-1])
  ) else $error("Write address register is off the chain.");

  chk_cap_on_chain: assert property (
    shift |=> st[`F_RDATA] == $past(st[`F_RDATA-1])
  ) else $error("Read capture register is off the chain.");

  chk_write_strobe: assert property (
    mtest && i_write_strobe && kind == scan_test_pkg::kind_ram
      |=> mem[$past(st[`F_WADDR +: `MEM_AW])] == $past(st[`F_WDATA +: `MEM_DW])
  ) else $error("Write strobe did not store the scanned word.");

  chk_read_strobe: assert property (
    mtest && i_read_strobe |=> st[`F_RDATA +: `MEM_DW] == $past(rd_word)
  ) else $error("Read strobe did not capture the memory word.");

  chk_rom_guard: assert property (
    kind != scan_test_pkg::kind_ram |-> !wr_en
  ) else $error("Non-RAM array was written.");

  chk_full_width: assert property (
    mtest && narrow |-> wr_d == st[`F_WDATA +: `MEM_DW]
  ) else $error("Test write was narrowed.");

  chk_test_idle: assert property (
    !i_test_mode ##1 !i_test_mode ##1 !i_test_mode |-> !shift && !mtest &&
      $stable(st[`F_SPARE +: `SPARE_W])
  ) else $error("Test logic active in user mode.");

  chk_mtest_off: assert property (
    !i_mem_test && !apb_wr |-> !wr_en
  ) else $error("Memory written with test mode off.");

  chk_spare_park: assert property (
    !shift |=> st[`F_SPARE +: `SPARE_W] == `SPARE_PARK
  ) else $error("Spare resource not parked.");

  // The next checks pin the chain order: five register boundaries, one inner read capture bit and two chain tails.
  chk_wdata_chain: assert property (
    shift |=> st[`F_WDATA] == $past(st[`F_WDATA-1])
  ) else $error("Write data register is off the chain.");

  chk_raddr_chain: assert property (
    shift |=> st[`F_RADDR] == $past(st[`F_RADDR-1])
  ) else $error("Read address register is off the chain.");

  chk_cap_tail: assert property (
    shift |=> st[`F_RDATA+`MEM_DW-1] == $past(st[`F_RDATA+`MEM_DW-2])
  ) else $error("Read capture register is broken inside the chain.");

  chk_scr_chain: assert property (
    shift |=> st[`F_SCR] == $past(st[`F_SCR-1])
  ) else $error("Scratch register is off the chain.");

  chk_rd_flop_chain: assert property (
    shift |=> st[`F_RD] == $past(st[`F_RD-1])
  ) else $error("Bus read register is off the chain.");

  chk_spare_chain: assert property (
    shift |=> st[`F_SPARE] == $past(st[`F_SPARE-1])
  ) else $error("Spare cell is off the chain.");

  chk_chain_tail: assert property (
    shift |=> o_scan_out[0] == $past(st[`CHAIN_LEN-2])
  ) else $error("Chain zero output is not its last bit.");

  chk_tail_two: assert property (
    shift |=> o_scan_out[2] == $past(st[(`CHAINS-1)*`CHAIN_LEN-2])
  ) else $error("Chain two output is not its last bit.");

  chk_shift_no_write: assert property (
    shift |-> !wr_en
  ) else $error("Memory written while shifting.");

  chk_ram_write: assert property (
    mtest && i_write_strobe && is_ram(kind)
      |-> wr_en && wr_a == st[`F_WADDR +: `MEM_AW]
  ) else $error("Write strobe did not reach a RAM array.");

  chk_test_hold: assert property (
    i_test_mode && !i_scan_en |=> $stable(st[`F_RDATA-1:`F_CFG])
  ) else $error("Configuration changed in test mode without shifting.");

  chk_narrow_user: assert property (
    apb_wr && i_paddr == `A_WDATA && narrow |-> (wr_d & ~`BYTE_MASK) == 16'h0
  ) else $error("Byte-wide user write reached the upper half.");

  chk_user_write: assert property (
    apb_wr && i_paddr == `A_WADDR
      |=> st[`F_WADDR +: `MEM_AW] == $past(i_pwdata[`MEM_AW-1:0])
  ) else $error("Write address was not taken in user mode.");

  chk_read_latch: assert property (
    i_psel && !i_penable && i_paddr == `A_SCR && !shift
      |=> o_prdata[`MEM_DW-1:0] == $past(st[`F_SCR +: `MEM_DW])
  ) else $error("Read data was not latched at the setup edge.");

  cov_shift: cover property (shift [*3]);
  cov_test_write: cover property (mtest && i_write_strobe ##1 mtest && i_read_strobe);
  cov_apb_read: cover property (i_psel && !i_penable ##1 i_psel && i_penable);
  cov_rom_block: cover property (mtest && i_write_strobe && kind != scan_test_pkg::kind_ram);
  cov_user_write: cover property (apb_wr && i_paddr == `A_WDATA);

endmodule // scan_mem_test

// [scan_tester.sv]
// Tester model that shifts the scan chains and pulses the memory strobes.
`timescale 1ns/1ps
module scan_tester (
  input wire logic i_clk_sys,
  input wire logic [3:0] i_scan_out,
  output logic o_scan_en,
  output logic [3:0] o_scan_in,
  output logic o_write_strobe,
  output logic o_read_strobe
);
  initial begin
    o_scan_en = 1'b0;
    o_scan_in = 4'h0;
    o_write_strobe = 1'b0;
    o_read_strobe = 1'b0;
  end
  // Loads all chains in parallel and unloads what they held before.
  task automatic shift(input logic [83:0] v, output logic [83:0] cap);
    for (int k = 0; k < 21; k++) begin
      @(posedge i_clk_sys);
      o_scan_en <= 1'b1;
      for (int c = 0; c < 4; c++) begin
        o_scan_in[c] <= v[21*c+20-k];
      end
      @(negedge i_clk_sys);
      for (int c = 0; c < 4; c++) begin
        cap[21*c+20-k] = i_scan_out[c];
      end
    end
    @(posedge i_clk_sys);
    o_scan_en <= 1'b0;
    o_scan_in <= ~o_scan_in;
  endtask
  task automatic strobe(input logic wr);
    @(posedge i_clk_sys);
    o_write_strobe <= wr;
    o_read_strobe <= !wr;
    @(posedge i_clk_sys);
    o_write_strobe <= 1'b0;
    o_read_strobe <= 1'b0;
  endtask
endmodule // scan_tester

// [testbench.sv]
// Self-checking bench for the scan and memory test block.
`timescale 1ns/1ps
`include "scan_test_consts.svh"
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic x;} row_t;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic test_mode = 1'b0;
  logic mem_test = 1'b0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic scan_en;
  logic wstb;
  logic rstb;
  logic [3:0] scan_in;
  logic [3:0] scan_out;
  logic [31:0] rd;
  logic err;
  logic [83:0] cap;
  int failures = 0;
  int checks = 0;
  row_t rows[6] = '{'{`A_CFG, 32'hffff_fff5, 32'h5, 1'b0},
    '{`A_WADDR, 32'hffff_ff85, 32'h5, 1'b0}, '{`A_RADDR, 32'h0000_00fa, 32'h7a, 1'b0},
    '{`A_SCR, 32'hffff_a55a, 32'ha55a, 1'b0}, '{`A_STATUS, 32'hffff_ffff, 32'h0, 1'b0},
    '{8'h1c, 32'h1, 32'h0, 1'b1}};
  always #5 i_clk_sys = ~i_clk_sys;
  scan_mem_test i_scan_mem_test (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_test_mode(test_mode),
    .i_scan_en(scan_en), .i_mem_test(mem_test), .i_scan_in(scan_in),
    .i_write_strobe(wstb), .i_read_strobe(rstb), .o_scan_out(scan_out));
  scan_tester i_scan_tester (.i_clk_sys(i_clk_sys), .i_scan_out(scan_out), .o_scan_en(scan_en),
    .o_scan_in(scan_in), .o_write_strobe(wstb), .o_read_strobe(rstb));
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    for (int a = 0; a < 7; a++) begin
      if (a != 4) begin
        apb(1'b0, 8'(4 * a), 32'h0);
        check("reset value", 32'h0, rd);
      end
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      check("register", rows[i].e, rd);
      check("error", {31'h0, rows[i].x}, {31'h0, err});
    end
    apb(1'b1, `A_CFG, 32'h0);
    apb(1'b1, `A_WDATA, 32'h1234);
    apb(1'b1, `A_RADDR, 32'h5);
    apb(1'b0, `A_RDATA, 32'h0);
    check("user ram", 32'h1234, rd);
    apb(1'b1, `A_CFG, 32'h4);
    apb(1'b1, `A_WDATA, 32'habcd);
    apb(1'b1, `A_CFG, 32'h1);
    apb(1'b1, `A_WDATA, 32'hffff);
    apb(1'b0, `A_RDATA, 32'h0);
    check("rom write", 32'h00cd, rd);
    apb(1'b1, `A_CFG, 32'h0);
    mem_test <= 1'b1;
    i_scan_tester.strobe(1'b1);
    apb(1'b0, `A_STATUS, 32'h0);
    check("status", 32'h2, rd);
    apb(1'b0, `A_RDATA, 32'h0);
    check("test inactive", 32'h00cd, rd);
    apb(1'b1, `A_CFG, 32'h1);
    test_mode <= 1'b1;
    mem_test <= 1'b0;
    i_scan_tester.shift(84'h0, cap);
    check("captured cfg", 32'h1, {29'h0, cap[2:0]});
    check("captured wdata", 32'hffff, {16'h0, cap[18:3]});
    for (int p = 0; p < 2; p++) begin
      i_scan_tester.shift({19'h0, 16'h5a5a, 16'h0, 7'h7f, 7'h7f,
        p ? 16'h1111 : 16'hbeef, p ? 3'h1 : 3'h4}, cap);
      mem_test <= 1'b1;
      i_scan_tester.strobe(1'b1);
      i_scan_tester.strobe(1'b0);
      mem_test <= 1'b0;
      i_scan_tester.shift(84'h0, cap);
      check("readback", 32'hbeef, {16'h0, cap[48:33]});
      check("scratch", 32'h5a5a, {16'h0, cap[64:49]});
    end
    test_mode <= 1'b0;
    apb(1'b0, `A_SCR, 32'h0);
    check("scan loaded", 32'h0, rd);
    apb(1'b1, `A_SCR, 32'h1357);
    apb(1'b1, `A_CFG, 32'h6);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    apb(1'b0, `A_SCR, 32'h0);
    check("reset scratch", 32'h0, rd);
    apb(1'b0, `A_CFG, 32'h0);
    check("reset cfg", 32'h0, rd);
    close_out();
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule // testbench
